// ---- rtl/phy_aux_params.svh ----
/*
 Constants for the per-port auxiliary PHY control/status register bank.
 Assumes a 200 MHz core clock and APB word access, byte address = index * 4.
*/
// What this block does
// - Five ports each own a copy, one page per port, pages 10h to 14h.
// - Gap mode on: 1-4 cycle gaps get two IDLEs inserted before next packet.
// - Bits 15:11 report the highest common mode, fastest full first.
// - First link-pass after reset or restart sets exactly one result bit.
// - Restart or reset clears all five result bits.
// - Later renegotiations may add result bits without clearing old ones.
// - Link-pass shows as a 1 in bit 7, with bit 6 also 1.
// - Writing 1 to bit 8 restarts negotiation; 0 does nothing; reads 0.
// - Restart works only while negotiation is enabled, like control bit 9.
// - Bit 7 sets on completion, held until restart, fault, reset or disable.
// - Bit 6 sets leaving acknowledge-complete, held until restart/fault/disable/reset.
// - Bit 5 sets leaving acknowledge-detected, held until restart or reset.
// - Bit 4 is 1 only while in the ability-detect state.
// - Ability-detect entered fixed time after start, left on partner pulses.
// - Bit 3 isolates: ignore transmit inputs, float receive data, no pulses.
// - Bit 1 enables 10BASE-T serial mode, never offered at 100 Mbps.
// - Bank bit 7 set: indices 1Eh to 3Ch go to the shadow bank.
// - Latched-high status bits hold until read and the read clears them; the latched-low link bit reloads from the link.
`ifndef PHY_AUX_PARAMS_SVH
`define PHY_AUX_PARAMS_SVH
`define NUM_PORTS 5
`define PAGE_FIRST 8'h10
`define IDX_STATUS_SUM 8'h32
`define IDX_GAP_MODE 8'h3A
`define IDX_MULTI_PHY 8'h3C
`define IDX_BANK_SEL 8'h3E
`define IDX_SHADOW_LO 8'h1E
`define IDX_SHADOW_HI 8'h3C
`define RST_GAP_MODE 16'h0000
`define RST_MULTI_PHY 16'h0000
`define RST_BANK_SEL 16'h000B
`define MPHY_RW_MASK 16'h060F
`define GAP_MODE_BIT 1
`define MPHY_RESTART_BIT 8
`define MPHY_ISO_BIT 3
`define MPHY_SERIAL_BIT 1
`define BANK_SHADOW_BIT 7
`define SUM_CHK_BIT 14
`define SUM_ACK_BIT 13
`define SUM_ABIL_BIT 12
`define SUM_LINK_BIT 2
`define CLK_PERIOD_NS 5
`define AN_START_NS 1000
`define GAP_MAX 3'h4
`define GAP_SAT 3'h5
`define IDLE_INSERT 2'h2
`define HCD_FAST_FULL 3'h5
`define HCD_FAST_FOUR 3'h4
`define HCD_FAST_HALF 3'h3
`define HCD_SLOW_FULL 3'h2
`endif

// ---- rtl/phy_aux_pkg.sv ----
/*
 Types for the auxiliary PHY register bank: pin groups, FSM and per-port state.
 Assumes the constants header is included by the design file.
*/
package phy_aux_pkg;
	typedef struct packed {
		logic an_enable;
		logic pulse_seen;
		logic ack_seen;
		logic link_ok;
		logic speed100;
		logic [2:0] hcd_code;
	} phy_in_t;

	typedef struct packed {
		logic insert_idle;
		logic tx_accept;
		logic rxd_oe;
		logic link_pulse_en;
		logic serial_en;
		logic shadow_en;
	} phy_out_t;

	typedef enum logic [6:0] {
		AN_OFF = 7'h01,
		AN_WAIT = 7'h02,
		AN_ABILITY = 7'h04,
		AN_ACK_DET = 7'h08,
		AN_ACK_CPL = 7'h10,
		AN_LINK_CHK = 7'h20,
		AN_LINK_PASS = 7'h40
	} an_state_t;

	typedef struct packed {
		an_state_t st;
		logic [23:0] timer;
		logic [15:0] gap_reg;
		logic [15:0] mphy_rw;
		logic [15:0] bank_reg;
		logic [4:0] result;
		logic an_cpl;
		logic ack_cpl;
		logic ack_det;
		logic lh_chk;
		logic lh_ack;
		logic lh_abil;
		logic ll_link;
		logic tx_prev;
		logic [2:0] gap_cnt;
		logic [1:0] idle_cnt;
	} port_state_t;
endpackage

// ---- rtl/phy_aux_negotiation_shadow_ctrl.sv ----
/*
 Per-port auxiliary PHY control/status bank with negotiation progress tracking,
 short-gap idle insertion, isolate and serial mode controls, APB slave.
 Assumes tx_en_i is on clk_i; phy_i comes from the PHY core asynchronously.
*/
`timescale 1ns/1ps
`include "phy_aux_params.svh"
module phy_aux_negotiation_shadow_ctrl #(
	parameter int NPORTS = `NUM_PORTS,
	parameter int AN_START_CYC = (`AN_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int AW = 20
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [NPORTS-1:0] tx_en_i,
	input wire phy_aux_pkg::phy_in_t [NPORTS-1:0] phy_i,
	output phy_aux_pkg::phy_out_t [NPORTS-1:0] phy_o
);
	localparam logic [23:0] START_LAST = 24'(AN_START_CYC - 1);

	typedef struct packed {
		phy_aux_pkg::port_state_t [NPORTS-1:0] port;
		phy_aux_pkg::phy_in_t [NPORTS-1:0] s1;
		phy_aux_pkg::phy_in_t [NPORTS-1:0] s2;
		logic [31:0] rdata;
		logic slverr;
	} ctrl_state_t;

	ctrl_state_t r_reg;
	ctrl_state_t r_next;

	function automatic logic [4:0] hcd_onehot(input logic [2:0] c);
		case (c)
			`HCD_FAST_FULL: hcd_onehot = 5'h10;
			`HCD_FAST_FOUR: hcd_onehot = 5'h08;
			`HCD_FAST_HALF: hcd_onehot = 5'h04;
			`HCD_SLOW_FULL: hcd_onehot = 5'h02;
			// Unknown code still yields one bit so the first pass is never empty
			default: hcd_onehot = 5'h01;
		endcase
	endfunction

	always_comb begin
		phy_aux_pkg::port_state_t ps;
		phy_aux_pkg::phy_in_t ip;
		logic [7:0] page;
		logic [7:0] idx;
		logic [7:0] pidx;
		logic setup;
		logic wr;
		logic rd;
		logic sel;
		logic shadow;
		logic hit_gap;
		logic hit_mphy;
		logic hit_bank;
		logic hit_sum;
		logic restart;
		logic en;
		logic [31:0] rd_data;
		logic mapped;
		ps = '0;
		ip = '0;
		sel = 1'b0;
		shadow = 1'b0;
		hit_gap = 1'b0;
		hit_mphy = 1'b0;
		hit_bank = 1'b0;
		hit_sum = 1'b0;
		restart = 1'b0;
		en = 1'b0;
		r_next = r_reg;
		r_next.s1 = phy_i;
		r_next.s2 = r_reg.s1;
		page = paddr_i[17:10];
		idx = paddr_i[9:2];
		pidx = page - `PAGE_FIRST;
		setup = psel_i & ~penable_i;
		wr = psel_i & penable_i & pwrite_i;
		rd = psel_i & penable_i & ~pwrite_i;
		rd_data = '0;
		mapped = 1'b0;
		for (int p = 0; p < NPORTS; p++) begin
			ps = r_reg.port[p];
			ip = r_reg.s2[p];
			sel = (page >= `PAGE_FIRST) && (pidx == 8'(p));
			shadow = ps.bank_reg[`BANK_SHADOW_BIT] && idx >= `IDX_SHADOW_LO
				&& idx <= `IDX_SHADOW_HI;
			hit_gap = sel && !shadow && idx == `IDX_GAP_MODE;
			hit_mphy = sel && !shadow && idx == `IDX_MULTI_PHY;
			hit_sum = sel && !shadow && idx == `IDX_STATUS_SUM;
			hit_bank = sel && idx == `IDX_BANK_SEL;

			// Read data latched in setup so prdata comes from a flop
			if (sel) begin
				mapped = shadow | hit_gap | hit_mphy | hit_sum | hit_bank;
				if (hit_gap)
					rd_data = {16'h0000, ps.gap_reg};
				if (hit_bank)
					rd_data = {16'h0000, ps.bank_reg};
				if (hit_mphy) begin
					rd_data = {16'h0000, ps.result, ps.mphy_rw[10:9], 1'b0,
						ps.an_cpl, ps.ack_cpl, ps.ack_det,
						ps.st == phy_aux_pkg::AN_ABILITY,
						ps.mphy_rw[3:0]};
				end
				if (hit_sum) begin
					rd_data[`SUM_CHK_BIT] = ps.lh_chk;
					rd_data[`SUM_ACK_BIT] = ps.lh_ack;
					rd_data[`SUM_ABIL_BIT] = ps.lh_abil;
					rd_data[`SUM_LINK_BIT] = ps.ll_link;
				end
			end

			if (wr && hit_gap)
				ps.gap_reg = pwdata_i[15:0];
			if (wr && hit_mphy)
				ps.mphy_rw = pwdata_i[15:0] & `MPHY_RW_MASK;
			if (wr && hit_bank)
				ps.bank_reg = pwdata_i[15:0];
			restart = wr && hit_mphy && pwdata_i[`MPHY_RESTART_BIT] && ip.an_enable;

			// Read clears only bits the reader saw, so a fresh set survives
			if (rd && hit_sum) begin
				ps.lh_chk = ps.lh_chk & ~r_reg.rdata[`SUM_CHK_BIT];
				ps.lh_ack = ps.lh_ack & ~r_reg.rdata[`SUM_ACK_BIT];
				ps.lh_abil = ps.lh_abil & ~r_reg.rdata[`SUM_ABIL_BIT];
				ps.ll_link = ip.link_ok;
			end
			if (!ip.link_ok)
				ps.ll_link = 1'b0;

			case (ps.st)
				phy_aux_pkg::AN_OFF: begin
					if (ip.an_enable) begin
						ps.st = phy_aux_pkg::AN_WAIT;
						ps.timer = '0;
					end
				end
				phy_aux_pkg::AN_WAIT: begin
					if (ps.timer >= START_LAST) begin
						ps.st = phy_aux_pkg::AN_ABILITY;
						ps.lh_abil = 1'b1;
					end else begin
						ps.timer = ps.timer + 24'h000001;
					end
				end
				phy_aux_pkg::AN_ABILITY: begin
					if (ip.pulse_seen) begin
						ps.st = phy_aux_pkg::AN_ACK_DET;
						ps.lh_ack = 1'b1;
					end
				end
				phy_aux_pkg::AN_ACK_DET: begin
					if (ip.ack_seen) begin
						ps.st = phy_aux_pkg::AN_ACK_CPL;
						ps.ack_det = 1'b1;
					end
				end
				phy_aux_pkg::AN_ACK_CPL: begin
					ps.st = phy_aux_pkg::AN_LINK_CHK;
					ps.ack_cpl = 1'b1;
					ps.lh_chk = 1'b1;
				end
				phy_aux_pkg::AN_LINK_CHK: begin
					if (ip.link_ok) begin
						ps.st = phy_aux_pkg::AN_LINK_PASS;
						ps.an_cpl = 1'b1;
						// Old bits kept: several may read 1 after renegotiation
						ps.result = ps.result | hcd_onehot(ip.hcd_code);
					end
				end
				phy_aux_pkg::AN_LINK_PASS: begin
					if (!ip.link_ok) begin
						ps.st = phy_aux_pkg::AN_WAIT;
						ps.timer = '0;
						ps.an_cpl = 1'b0;
						ps.ack_cpl = 1'b0;
					end
				end
				default: begin
					ps.st = phy_aux_pkg::AN_OFF;
				end
			endcase

			if (!ip.an_enable) begin
				ps.st = phy_aux_pkg::AN_OFF;
				ps.an_cpl = 1'b0;
				ps.ack_cpl = 1'b0;
			end
			if (restart) begin
				ps.st = phy_aux_pkg::AN_WAIT;
				ps.timer = '0;
				ps.result = '0;
				ps.an_cpl = 1'b0;
				ps.ack_cpl = 1'b0;
				ps.ack_det = 1'b0;
			end

			// Gap counter saturates so an idle line never triggers insertion
			en = tx_en_i[p] & ~ps.mphy_rw[`MPHY_ISO_BIT];
			if (ps.idle_cnt != 2'h0)
				ps.idle_cnt = ps.idle_cnt - 2'h1;
			if (en && !ps.tx_prev) begin
				if (ps.gap_reg[`GAP_MODE_BIT] && ps.gap_cnt != 3'h0
					&& ps.gap_cnt <= `GAP_MAX)
					ps.idle_cnt = `IDLE_INSERT;
				ps.gap_cnt = 3'h0;
			end else if (!en && ps.gap_cnt < `GAP_SAT) begin
				ps.gap_cnt = ps.gap_cnt + 3'h1;
			end
			ps.tx_prev = en;
			r_next.port[p] = ps;
		end
		if (setup) begin
			r_next.rdata = rd_data;
			r_next.slverr = ~mapped;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			r_reg <= '0;
			for (int p = 0; p < NPORTS; p++) begin
				r_reg.port[p].st <= phy_aux_pkg::AN_OFF;
				r_reg.port[p].gap_reg <= `RST_GAP_MODE;
				r_reg.port[p].mphy_rw <= `RST_MULTI_PHY;
				r_reg.port[p].bank_reg <= `RST_BANK_SEL;
				r_reg.port[p].gap_cnt <= `GAP_SAT;
			end
		end else if (ce_i) begin
			r_reg <= r_next;
		end
	end

	always_comb begin
		for (int p = 0; p < NPORTS; p++) begin
			phy_o[p].insert_idle = r_reg.port[p].idle_cnt != 2'h0;
			phy_o[p].tx_accept = ~r_reg.port[p].mphy_rw[`MPHY_ISO_BIT];
			phy_o[p].rxd_oe = ~r_reg.port[p].mphy_rw[`MPHY_ISO_BIT];
			phy_o[p].link_pulse_en = ~r_reg.port[p].mphy_rw[`MPHY_ISO_BIT];
			// Speed comes from the synchronised PHY status, never the raw pin
			phy_o[p].serial_en = r_reg.port[p].mphy_rw[`MPHY_SERIAL_BIT]
				& ~r_reg.s2[p].speed100;
			phy_o[p].shadow_en = r_reg.port[p].bank_reg[`BANK_SHADOW_BIT];
		end
	end

	// Answer needs no wait state beyond the clock enable
	assign pready_o = ce_i;
	assign prdata_o = r_reg.rdata;
	assign pslverr_o = r_reg.slverr;
endmodule

// ---- tb/link_partner_model.sv ----
/*
 Remote link partner seen through the PHY core status lines of one port.
 Assumes the bench sets its pace with dly_i and forces link faults with fault_i.
*/
`timescale 1ns/1ps
module link_partner_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic fault_i,
	input wire logic speed100_i,
	input wire logic [2:0] hcd_i,
	input wire logic [5:0] dly_i,
	output phy_aux_pkg::phy_in_t line_o
);
	logic [7:0] cnt_reg;
	logic [7:0] d;
	assign d = {2'b00, dly_i};
	// Saturating count keeps the partner in its final state
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			cnt_reg <= 8'h00;
		else if (!en_i)
			cnt_reg <= 8'h00;
		else if (cnt_reg != 8'hFF)
			cnt_reg <= cnt_reg + 8'h01;
	end
	always_comb begin
		line_o.an_enable = en_i;
		line_o.pulse_seen = en_i && cnt_reg >= d;
		line_o.ack_seen = en_i && cnt_reg >= d + d;
		line_o.link_ok = en_i && !fault_i && cnt_reg >= d + d + d;
		line_o.speed100 = speed100_i;
		line_o.hcd_code = hcd_i;
	end
endmodule

// ---- tb/phy_aux_asserts.sv ----
/*
 Checker for the auxiliary PHY register bank, bound to its top module.
 Assumes port 0 stands for all ports; bus checks count only enabled cycles.
*/
`timescale 1ns/1ps
module phy_aux_checker #(
	parameter int NPORTS = 5,
	parameter int AW = 20
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [NPORTS-1:0] tx_en_i,
	input wire phy_aux_pkg::phy_in_t [NPORTS-1:0] phy_i,
	input wire phy_aux_pkg::phy_out_t [NPORTS-1:0] phy_o
);
	logic setup;
	logic [7:0] page;
	assign setup = psel_i && !penable_i && ce_i;
	assign page = paddr_i[17:10];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	bad_page_err_a: assert property (setup && (page < 8'h10 || page > 8'h14) |=> pslverr_o)
		else $error("unmapped page answered without error");
	restart_reads_zero_a: assert property (setup && page == 8'h10 && paddr_i[9:2] == 8'h3C
		|=> !pslverr_o && !prdata_o[8]) else $error("restart bit read as one");
	ability_excl_a: assert property (setup && !pwrite_i && paddr_i[9:2] == 8'h3C
		|=> !(prdata_o[4] && prdata_o[7])) else $error("ability and complete both set");
	idle_two_a: assert property ($rose(phy_o[0].insert_idle)
		|-> phy_o[0].insert_idle [*2] ##1 !phy_o[0].insert_idle) else $error("idle length wrong");
	idle_cause_a: assert property ($rose(phy_o[0].insert_idle)
		|-> $past(tx_en_i[0]) && !$past(tx_en_i[0], 2)) else $error("idle without packet start");
	iso_group_a: assert property (phy_o[0].tx_accept == phy_o[0].rxd_oe
		&& phy_o[0].rxd_oe == phy_o[0].link_pulse_en) else $error("isolate outputs disagree");
	serial_speed_a: assert property (phy_i[0].speed100 [*5] |-> !phy_o[0].serial_en)
		else $error("serial mode at fast speed");
	shadow_write_a: assert property (psel_i && penable_i && ce_i && pwrite_i && page == 8'h10
		&& paddr_i[9:2] == 8'h3E |=> phy_o[0].shadow_en == $past(pwdata_i[7]))
		else $error("shadow enable not following write");
	cover property ($rose(phy_o[0].insert_idle));
	cover property (pslverr_o);
	cover property ($rose(phy_o[0].shadow_en));
endmodule
bind phy_aux_negotiation_shadow_ctrl phy_aux_checker #(.NPORTS(NPORTS), .AW(AW)) phy_aux_checker_i (
	.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .tx_en_i(tx_en_i), .phy_i(phy_i), .phy_o(phy_o));

// ---- tb/tb.sv ----
/*
 Self-checking bench for the auxiliary PHY register bank; port 0 negotiates.
 Assumes the partner model and the checker are compiled before it.
*/
`timescale 1ns/1ps
`include "phy_aux_params.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %0t got %h want %h", $time, g, e); end end
module tb;
	logic clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, last_err, pready, pslverr;
	logic ce = 1;
	logic [19:0] paddr = 20'h00000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic [4:0] tx_en = 5'h00, en = 5'h00, fault = 5'h00, spd = 5'h00;
	logic [2:0] highest_common_mode = 3'h5;
	logic [5:0] dly = 6'h14;
	phy_aux_pkg::phy_in_t [4:0] line;
	phy_aux_pkg::phy_out_t [4:0] phy_o;
	int bad_count = 0, n_compared = 0;
	phy_aux_negotiation_shadow_ctrl #(.AN_START_CYC(4)) phy_aux_negotiation_shadow_ctrl_i (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .tx_en_i(tx_en), .phy_i(line), .phy_o(phy_o));
	for (genvar g = 0; g < 5; g++) begin : lp
		link_partner_model link_partner_model_i (.clk_i(clk_i), .rst_i(rst_i), .en_i(en[g]),
			.fault_i(fault[g]), .speed100_i(spd[g]), .hcd_i(highest_common_mode), .dly_i(dly), .line_o(line[g]));
	end
	function automatic logic [19:0] ad(input int p, input logic [7:0] i);
		return {2'b00, 8'h10 + 8'(p), i, 2'b00};
	endfunction
	task automatic apb(input logic w, input logic [19:0] a, input logic [15:0] d);
		@(posedge clk_i);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk_i);
		penable <= 1;
		// Only the watchdog ends a wait for pready
		do begin
			@(posedge clk_i);
		end while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic poll(input int b);
		int n;
		n = 0;
		do begin
			apb(0, ad(0, `IDX_MULTI_PHY), 16'h0000);
			n++;
		end while (rd[b] !== 1'b1 && n < 200);
	endtask
	task automatic t_reset;
		for (int p = 0; p < 5; p++) begin
			apb(0, ad(p, `IDX_GAP_MODE), 16'h0000);
			`CHK(rd, {16'h0000, `RST_GAP_MODE})
			apb(0, ad(p, `IDX_MULTI_PHY), 16'h0000);
			`CHK(rd, {16'h0000, `RST_MULTI_PHY})
			apb(0, ad(p, `IDX_BANK_SEL), 16'h0000);
			`CHK(rd, {16'h0000, `RST_BANK_SEL})
		end
		apb(0, ad(5, `IDX_GAP_MODE), 16'h0000);
		`CHK({last_err, rd}, 33'h100000000)
	endtask
	task automatic t_neg;
		en[0] <= 1;
		poll(4);
		`CHK(rd[15:0], 16'h0010)
		poll(7);
		`CHK(rd[15:0], 16'h80E0)
		apb(0, ad(0, `IDX_STATUS_SUM), 16'h0000);
		`CHK({rd[14:12], rd[2]}, 4'hE)
		apb(0, ad(0, `IDX_STATUS_SUM), 16'h0000);
		`CHK({rd[14:12], rd[2]}, 4'h1)
		apb(1, ad(0, `IDX_MULTI_PHY), 16'hF8F0);
		apb(0, ad(0, `IDX_MULTI_PHY), 16'h0000);
		`CHK(rd[15:0], 16'h80E0)
		dly <= 6'h0C;
		for (int c = 5; c >= 1; c--) begin
			highest_common_mode <= 3'(c);
			apb(1, ad(0, `IDX_MULTI_PHY), 16'h0100);
			apb(0, ad(0, `IDX_MULTI_PHY), 16'h0000);
			`CHK(rd[15:0], 16'h0000)
			poll(7);
			`CHK(rd[15:0], 16'h00E0 | (16'h0001 << (10 + c)))
		end
	endtask
	task automatic t_fault;
		highest_common_mode <= 3'h3;
		fault[0] <= 1;
		repeat (10) @(posedge clk_i);
		fault[0] <= 0;
		poll(7);
		`CHK(rd[15:0], 16'h28E0)
		en[0] <= 0;
		repeat (6) @(posedge clk_i);
		apb(0, ad(0, `IDX_MULTI_PHY), 16'h0000);
		`CHK(rd[15:0], 16'h2820)
		apb(1, ad(0, `IDX_MULTI_PHY), 16'h0100);
		apb(0, ad(0, `IDX_MULTI_PHY), 16'h0000);
		`CHK(rd[15:0], 16'h2820)
	endtask
	task automatic t_gap;
		int c;
		apb(1, ad(0, `IDX_GAP_MODE), 16'h0002);
		for (int k = 1; k <= 5; k++) begin
			tx_en[0] <= 1;
			repeat (3) @(posedge clk_i);
			tx_en[0] <= 0;
			repeat (k) @(posedge clk_i);
			tx_en[0] <= 1;
			c = 0;
			repeat (6) begin
				@(posedge clk_i);
				#1 c += int'(phy_o[0].insert_idle === 1'b1);
			end
			`CHK(c, (k <= 4) ? 2 : 0)
			@(posedge clk_i);
			tx_en[0] <= 0;
			repeat (8) @(posedge clk_i);
		end
	endtask
	task automatic t_iso;
		apb(1, ad(0, `IDX_MULTI_PHY), 16'h000A);
		@(posedge clk_i);
		#1 `CHK({phy_o[0].tx_accept, phy_o[0].rxd_oe, phy_o[0].link_pulse_en, phy_o[0].serial_en},
			4'h1)
		@(posedge clk_i);
		spd[0] <= 1;
		repeat (5) @(posedge clk_i);
		#1 `CHK(phy_o[0].serial_en, 1'b0)
		apb(1, ad(0, `IDX_MULTI_PHY), 16'h0000);
		@(posedge clk_i);
		#1 `CHK(phy_o[0].tx_accept, 1'b1)
	endtask
	task automatic t_shadow;
		apb(1, ad(0, `IDX_GAP_MODE), 16'h0002);
		apb(1, ad(0, `IDX_BANK_SEL), 16'h008B);
		#1 `CHK(phy_o[0].shadow_en, 1'b1)
		apb(1, ad(0, `IDX_GAP_MODE), 16'h0000);
		apb(0, ad(0, `IDX_GAP_MODE), 16'h0000);
		`CHK({last_err, rd}, 33'h000000000)
		apb(1, ad(0, `IDX_BANK_SEL), 16'h000B);
		apb(0, ad(0, `IDX_GAP_MODE), 16'h0000);
		`CHK(rd, 32'h00000002)
	endtask
	// Clock enable low: bus stalls and no state moves until it returns
	task automatic t_ce;
		ce <= 0;
		fork
			apb(1, ad(1, `IDX_BANK_SEL), 16'h008B);
			begin
				repeat (4) @(posedge clk_i);
				#1 `CHK({pready, phy_o[1].shadow_en}, 2'b00)
				@(posedge clk_i);
				ce <= 1;
			end
		join
		#1 `CHK(phy_o[1].shadow_en, 1'b1)
	endtask
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		t_reset();
		t_neg();
		t_fault();
		t_gap();
		t_iso();
		t_shadow();
		t_ce();
		conclude();
	end
	// Whole run needs a few hundred cycles; only a hang reaches the cap far above that
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		conclude();
	end
endmodule
